// ===== hw/pmc_cmp_wake.sv
`timescale 1ns/1ns
// comparator edge detection; cfg holds rise and fall enables per comparator
module pmc_cmp_wake
(
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic [pmc_pkg::NUM_CMP-1:0] cmp_out,
    pmc_wake_if.cmp                          wk
);

    logic [pmc_pkg::NUM_CMP-1:0] prev_reg;
    logic [pmc_pkg::NUM_CMP-1:0] wake_reg;

    assign wk.cmp_wake = wake_reg;

    genvar i;
    generate
        for (i = 0; i < pmc_pkg::NUM_CMP; i++)
        begin : g_cmp
            wire rise_w = cmp_out[i] & ~prev_reg[i];
            wire fall_w = ~cmp_out[i] & prev_reg[i];
            // either edge when both enables are set
            wire hit_w  = (rise_w & wk.cmp_cfg[2*i]) |
                          (fall_w & wk.cmp_cfg[2*i+1]);

            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    prev_reg[i] <= 1'b0;
                    wake_reg[i] <= 1'b0;
                end
                else
                begin
                    prev_reg[i] <= cmp_out[i];
                    wake_reg[i] <= hit_w;
                end
            end
        end
    endgenerate

endmodule

// ===== hw/pmc_pkg.sv
// Summary of operation
// - active: system clock runs, core fetches, peripherals follow own settings
// - power control bit 0 enters idle; enabled interrupt or reset resumes
// - osc control bit 5 enters suspend; system clock and its peripherals stop
// - suspend ends only on wake event, external or missing clock reset
// - power control bit 1 enters stop; core, interrupts, timers, oscillator off
// - stop: digital and rtc off, analog held (analog_run is driven off here); only external/missing clock reset
// - debug halt, step or breakpoint stalls peripherals except converter, smbus
// - comparator rising, falling or either edge wakes idle or suspend
// - rtc alarm or oscillator fail raises interrupt, wake or reset per config
package pmc_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_PWR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_OSC_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_WAKE_CFG  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h0c;
    localparam logic [7:0] ADDR_STATUS    = 8'h10;

    // field positions
    localparam int BIT_IDLE        = 0;
    localparam int BIT_STOP        = 1;
    localparam int BIT_SUSPEND     = 5;
    localparam int BIT_ST_STALL    = 4;
    localparam int CMP_CFG_W       = 4;
    localparam int RTC_CFG_LSB     = 4;
    localparam int RTC_CFG_W       = 6;
    localparam int WAKE_CFG_W      = CMP_CFG_W + RTC_CFG_W;
    localparam int IRQ_W           = 8;
    localparam int NUM_CMP         = 2;

    // reset values
    localparam logic [WAKE_CFG_W-1:0] WAKE_CFG_RST = 10'h000;
    localparam logic [IRQ_W-1:0]      IRQ_EN_RST   = 8'h00;

    // status mode codes
    localparam logic [1:0] CODE_ACTIVE  = 2'h0;
    localparam logic [1:0] CODE_IDLE    = 2'h1;
    localparam logic [1:0] CODE_SUSPEND = 2'h2;
    localparam logic [1:0] CODE_STOP    = 2'h3;

    typedef enum logic [1:0]
    {
        MODE_ACTIVE,
        MODE_IDLE,
        MODE_SUSPEND,
        MODE_STOP
    } pmc_mode_t;

endpackage

// ===== hw/pmc_power_ctrl.sv
`timescale 1ns/1ns
// power mode controller: apb registers, mode machine and gating outputs
module pmc_power_ctrl
(
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [pmc_pkg::IRQ_W-1:0]   irq_req,
    input  wire logic                        ext_reset_evt,
    input  wire logic                        mcd_reset_evt,
    input  wire logic                        other_reset_evt,
    input  wire logic                        dbg_halt,
    input  wire logic [pmc_pkg::NUM_CMP-1:0] cmp_out,
    input  wire logic                        rtc_alarm,
    input  wire logic                        rtc_osc_fail,
    output logic                             cpu_fetch_en,
    output logic                             system_clock_en,
    output logic                             osc_en,
    output logic                             dig_periph_run,
    output logic                             analog_run,
    output logic                             irq_timer_en,
    output logic                             rtc_run,
    output logic                             periph_stall,
    output logic                             rtc_irq,
    output logic                             rtc_reset_req
);

    pmc_wake_if wk ();

    pmc_pkg::pmc_mode_t mode_reg;
    pmc_pkg::pmc_mode_t mode_next;

    logic [pmc_pkg::WAKE_CFG_W-1:0] wake_cfg_reg;
    logic [pmc_pkg::IRQ_W-1:0]      irq_en_reg;
    logic [31:0]                    prdata_reg;
    logic                           pready_reg;
    logic                           pslverr_reg;
    logic                           fetch_reg;
    logic                           system_clock_reg;
    logic                           osc_reg;
    logic                           dig_reg;
    logic                           ana_reg;
    logic                           irqt_reg;
    logic                           rtc_run_reg;
    logic                           stall_reg;
    logic                           rtc_irq_reg;
    logic                           rtc_rst_reg;
    logic [1:0]                     mode_code;

    pmc_cmp_wake u_cmp
    (
        .clk     (clk),
        .srst    (srst),
        .cmp_out (cmp_out),
        .wk      (wk.cmp)
    );

    pmc_rtc_route u_rtc
    (
        .clk          (clk),
        .srst         (srst),
        .rtc_alarm    (rtc_alarm),
        .rtc_osc_fail (rtc_osc_fail),
        .wk           (wk.rtc)
    );

    // configuration handed to the wake sources
    assign wk.cmp_cfg    = wake_cfg_reg[pmc_pkg::CMP_CFG_W-1:0];
    assign wk.rtc_cfg    = wake_cfg_reg[pmc_pkg::WAKE_CFG_W-1:
                                        pmc_pkg::RTC_CFG_LSB];
    assign wk.rtc_active = rtc_run_reg;

    // apb decode; one wait state so read data comes from a flop
    wire acc_w     = psel & penable;
    wire commit_w  = acc_w & pready_reg;
    wire wr_w      = commit_w & pwrite;
    wire sel_pwr   = (paddr == pmc_pkg::ADDR_PWR_CTRL);
    wire sel_osc   = (paddr == pmc_pkg::ADDR_OSC_CTRL);
    wire sel_wcfg  = (paddr == pmc_pkg::ADDR_WAKE_CFG);
    wire sel_irqen = (paddr == pmc_pkg::ADDR_IRQ_EN);
    wire sel_stat  = (paddr == pmc_pkg::ADDR_STATUS);
    wire mapped_w  = sel_pwr | sel_osc | sel_wcfg | sel_irqen | sel_stat;
    // status is read only; a write to it is refused with an error
    wire bad_w     = ~mapped_w | (pwrite & sel_stat);

    // mode requests carried by a committed write
    wire req_idle_w    = wr_w & sel_pwr & pwdata[pmc_pkg::BIT_IDLE];
    wire req_stop_w    = wr_w & sel_pwr & pwdata[pmc_pkg::BIT_STOP];
    wire req_suspend_w = wr_w & sel_osc & pwdata[pmc_pkg::BIT_SUSPEND];

    // exit causes
    wire hard_rst_w  = ext_reset_evt | mcd_reset_evt;
    wire any_rst_w   = hard_rst_w | other_reset_evt | wk.rtc_reset;
    wire en_irq_w    = (|(irq_req & irq_en_reg)) | wk.rtc_irq;
    wire cmp_wake_w  = |wk.cmp_wake;
    wire susp_wake_w = cmp_wake_w | wk.rtc_wake;

    // mode machine
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            pmc_pkg::MODE_ACTIVE:
            begin
                if (req_stop_w)
                    mode_next = pmc_pkg::MODE_STOP;
                else if (req_idle_w)
                    mode_next = pmc_pkg::MODE_IDLE;
                else if (req_suspend_w)
                    mode_next = pmc_pkg::MODE_SUSPEND;
            end
            pmc_pkg::MODE_IDLE:
            begin
                if (en_irq_w | cmp_wake_w | any_rst_w)
                    mode_next = pmc_pkg::MODE_ACTIVE;
            end
            pmc_pkg::MODE_SUSPEND:
            begin
                if (susp_wake_w | hard_rst_w)
                    mode_next = pmc_pkg::MODE_ACTIVE;
            end
            pmc_pkg::MODE_STOP:
            begin
                if (hard_rst_w)
                    mode_next = pmc_pkg::MODE_ACTIVE;
            end
            default:
                mode_next = pmc_pkg::MODE_ACTIVE;
        endcase
    end

    // gating per mode, registered so each output leaves a flop
    wire n_act  = (mode_next == pmc_pkg::MODE_ACTIVE);
    wire n_idle = (mode_next == pmc_pkg::MODE_IDLE);
    wire n_stop = (mode_next == pmc_pkg::MODE_STOP);
    wire n_susp = (mode_next == pmc_pkg::MODE_SUSPEND);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_reg    <= pmc_pkg::MODE_ACTIVE;
            fetch_reg   <= 1'b1;
            system_clock_reg  <= 1'b1;
            osc_reg     <= 1'b1;
            dig_reg     <= 1'b1;
            ana_reg     <= 1'b1;
            irqt_reg    <= 1'b1;
            rtc_run_reg <= 1'b1;
        end
        else
        begin
            mode_reg    <= mode_next;
            fetch_reg   <= n_act;
            system_clock_reg  <= n_act | n_idle;
            osc_reg     <= ~n_stop;
            dig_reg     <= n_act | n_idle;
            ana_reg     <= ~(n_susp | n_stop);
            irqt_reg    <= ~n_stop;
            rtc_run_reg <= ~n_stop;
        end
    end

    // debug stall; converter and smbus take no stall input at all
    // rtc events forwarded as one-cycle pulses
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stall_reg   <= 1'b0;
            rtc_irq_reg <= 1'b0;
            rtc_rst_reg <= 1'b0;
        end
        else
        begin
            stall_reg   <= dbg_halt;
            rtc_irq_reg <= wk.rtc_irq;
            rtc_rst_reg <= wk.rtc_reset;
        end
    end

    // software configuration
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wake_cfg_reg <= pmc_pkg::WAKE_CFG_RST;
            irq_en_reg   <= pmc_pkg::IRQ_EN_RST;
        end
        else
        begin
            if (wr_w & sel_wcfg)
                wake_cfg_reg <= pwdata[pmc_pkg::WAKE_CFG_W-1:0];
            if (wr_w & sel_irqen)
                irq_en_reg <= pwdata[pmc_pkg::IRQ_W-1:0];
        end
    end

    // mode code for software
    always_comb
    begin
        case (mode_reg)
            pmc_pkg::MODE_IDLE:    mode_code = pmc_pkg::CODE_IDLE;
            pmc_pkg::MODE_SUSPEND: mode_code = pmc_pkg::CODE_SUSPEND;
            pmc_pkg::MODE_STOP:    mode_code = pmc_pkg::CODE_STOP;
            default:               mode_code = pmc_pkg::CODE_ACTIVE;
        endcase
    end

    // read mux; mode bits read back as set while the mode holds
    wire [31:0] rd_pwr  = {30'h0, mode_code == pmc_pkg::CODE_STOP,
                           mode_code == pmc_pkg::CODE_IDLE};
    wire [31:0] rd_osc  = {26'h0, mode_code == pmc_pkg::CODE_SUSPEND,
                           5'h00};
    wire [31:0] rd_wcfg = {22'h0, wake_cfg_reg};
    wire [31:0] rd_irq  = {24'h0, irq_en_reg};
    wire [31:0] rd_stat = {27'h0, stall_reg, 2'h0, mode_code};
    wire [31:0] rd_w    = sel_pwr   ? rd_pwr  :
                          sel_osc   ? rd_osc  :
                          sel_wcfg  ? rd_wcfg :
                          sel_irqen ? rd_irq  :
                          sel_stat  ? rd_stat : 32'h0;

    // apb answer: pready rises in the second access cycle for one cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end
        else
        begin
            pready_reg  <= acc_w & ~pready_reg;
            pslverr_reg <= acc_w & ~pready_reg & bad_w;
            if (acc_w & ~pready_reg & ~pwrite)
                prdata_reg <= rd_w;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign cpu_fetch_en    = fetch_reg;
    assign system_clock_en = system_clock_reg;
    assign osc_en          = osc_reg;
    assign dig_periph_run  = dig_reg;
    assign analog_run      = ana_reg;
    assign irq_timer_en    = irqt_reg;
    assign rtc_run         = rtc_run_reg;
    assign periph_stall    = stall_reg;
    assign rtc_irq         = rtc_irq_reg;
    assign rtc_reset_req   = rtc_rst_reg;

endmodule

// ===== hw/pmc_rtc_route.sv
`timescale 1ns/1ns
// routes rtc alarm and oscillator fail to irq, wake or reset actions
module pmc_rtc_route
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic rtc_alarm,
    input  wire logic rtc_osc_fail,
    pmc_wake_if.rtc   wk
);

    logic alarm_prev_reg;
    logic fail_prev_reg;
    logic irq_reg;
    logic wake_reg;
    logic rst_reg;

    // cfg: [0] alarm irq [1] alarm wake [2] alarm reset, [5:3] same for fail
    // rtc is dead in stop, so its events are masked there
    wire alarm_w = rtc_alarm & ~alarm_prev_reg & wk.rtc_active;
    wire fail_w  = rtc_osc_fail & ~fail_prev_reg & wk.rtc_active;

    wire irq_w  = (alarm_w & wk.rtc_cfg[0]) | (fail_w & wk.rtc_cfg[3]);
    wire wake_w = (alarm_w & wk.rtc_cfg[1]) | (fail_w & wk.rtc_cfg[4]);
    wire rst_w  = (alarm_w & wk.rtc_cfg[2]) | (fail_w & wk.rtc_cfg[5]);

    assign wk.rtc_irq   = irq_reg;
    assign wk.rtc_wake  = wake_reg;
    assign wk.rtc_reset = rst_reg;

    // one-cycle event pulses on rising edges
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            alarm_prev_reg <= 1'b0;
            fail_prev_reg  <= 1'b0;
            irq_reg        <= 1'b0;
            wake_reg       <= 1'b0;
            rst_reg        <= 1'b0;
        end
        else
        begin
            alarm_prev_reg <= rtc_alarm;
            fail_prev_reg  <= rtc_osc_fail;
            irq_reg        <= irq_w;
            wake_reg       <= wake_w;
            rst_reg        <= rst_w;
        end
    end

endmodule

// ===== hw/pmc_wake_if.sv
`timescale 1ns/1ns
// configuration out to the wake sources and their events back
interface pmc_wake_if;
    logic [pmc_pkg::CMP_CFG_W-1:0] cmp_cfg;
    logic [pmc_pkg::RTC_CFG_W-1:0] rtc_cfg;
    logic                          rtc_active;
    logic [pmc_pkg::NUM_CMP-1:0]   cmp_wake;
    logic                          rtc_irq;
    logic                          rtc_wake;
    logic                          rtc_reset;

    modport ctrl (output cmp_cfg, output rtc_cfg, output rtc_active,
                  input cmp_wake, input rtc_irq, input rtc_wake,
                  input rtc_reset);
    modport cmp  (input cmp_cfg, output cmp_wake);
    modport rtc  (input rtc_cfg, input rtc_active, output rtc_irq,
                  output rtc_wake, output rtc_reset);
endinterface

// ===== sim/pmc_far_model.sv
`timescale 1ns/1ns
// wake and reset sources plus the core's interrupt lines, one event per go
module pmc_far_model
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ev_go,
    input  wire logic [2:0] ev_code,
    output logic      [7:0] irq_req,
    output logic            ext_reset_evt,
    output logic            mcd_reset_evt,
    output logic            other_reset_evt,
    output logic      [1:0] cmp_out,
    output logic            rtc_alarm,
    output logic            rtc_osc_fail
);
    initial
    begin
        {irq_req, ext_reset_evt, mcd_reset_evt, other_reset_evt} = '0;
        {cmp_out, rtc_alarm, rtc_osc_fail} = '0;
    end

    // events are one-cycle pulses; comparators hold their level and toggle
    always @(posedge clk)
    begin
        {irq_req, ext_reset_evt, mcd_reset_evt, other_reset_evt} <= '0;
        {rtc_alarm, rtc_osc_fail} <= 2'h0;
        if (srst)
            cmp_out <= 2'h0;
        else if (ev_go)
            case (ev_code)
                3'h0: ext_reset_evt <= 1'b1;
                3'h1: mcd_reset_evt <= 1'b1;
                3'h2: other_reset_evt <= 1'b1;
                3'h3: cmp_out[0] <= ~cmp_out[0];
                3'h4: cmp_out[1] <= ~cmp_out[1];
                3'h5: rtc_alarm <= 1'b1;
                3'h6: rtc_osc_fail <= 1'b1;
                default: irq_req <= 8'h08;
            endcase
    end
endmodule

// ===== sim/pmc_power_checker.sv
`timescale 1ns/1ns
// watches mode entry, exit and gating at the top ports
module pmc_power_checker
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        ext_reset_evt,
    input wire logic        mcd_reset_evt,
    input wire logic        other_reset_evt,
    input wire logic        dbg_halt,
    input wire logic        cpu_fetch_en,
    input wire logic        system_clock_en,
    input wire logic        osc_en,
    input wire logic        dig_periph_run,
    input wire logic        analog_run,
    input wire logic        irq_timer_en,
    input wire logic        rtc_run,
    input wire logic        periph_stall
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // outputs load on the same edge as the mode register; the two-cycle waits keep one spare edge
    wire wr_pwr  = psel && penable && pwrite && pready && paddr == 8'h00;
    wire wr_osc  = psel && penable && pwrite && pready && paddr == 8'h04;
    wire in_idle = !cpu_fetch_en && system_clock_en;

    fetch_gate_a: assert property (cpu_fetch_en |-> system_clock_en && osc_en && dig_periph_run)
        else $error("fetch without clock");
    stop_gate_a: assert property (!osc_en |-> !(system_clock_en || cpu_fetch_en || dig_periph_run || analog_run || irq_timer_en || rtc_run))
        else $error("stop gating wrong");
    susp_gate_a: assert property (!system_clock_en && osc_en |-> !cpu_fetch_en && !dig_periph_run && !analog_run)
        else $error("suspend gating wrong");
    idle_entry_a: assert property (wr_pwr && pwdata[1:0] == 2'h1 && cpu_fetch_en |-> ##2 in_idle)
        else $error("idle not entered");
    stop_entry_a: assert property (wr_pwr && pwdata[1] && cpu_fetch_en |-> ##2 !osc_en)
        else $error("stop not entered");
    susp_entry_a: assert property (wr_osc && pwdata[5] && cpu_fetch_en |-> ##2 !system_clock_en && osc_en)
        else $error("suspend not entered");
    stop_hold_a: assert property (!osc_en && !ext_reset_evt && !mcd_reset_evt |=> !osc_en)
        else $error("stop left without reset");
    stop_exit_a: assert property (!osc_en && (ext_reset_evt || mcd_reset_evt) |-> ##2 cpu_fetch_en && osc_en)
        else $error("stop not left on reset");
    idle_exit_a: assert property (in_idle && other_reset_evt |-> ##2 cpu_fetch_en)
        else $error("idle not left on reset");
    stall_follow_a: assert property (!$past(srst) |-> periph_stall == $past(dbg_halt))
        else $error("stall does not follow halt");

    idle_seen_c: cover property (in_idle ##1 other_reset_evt);
    susp_seen_c: cover property (!system_clock_en && osc_en);
    stop_left_c: cover property (!osc_en && ext_reset_evt);
endmodule

// ===== sim/pmc_power_ctrl_test.sv
`timescale 1ns/1ns
// mode table first, then refusal, debug, rtc and reset cases
module pmc_power_ctrl_test;
    localparam logic [7:0] PWR = pmc_pkg::ADDR_PWR_CTRL;
    localparam logic [7:0] OSC = pmc_pkg::ADDR_OSC_CTRL;
    localparam logic [7:0] WK  = pmc_pkg::ADDR_WAKE_CFG;
    localparam logic [7:0] IEN = pmc_pkg::ADDR_IRQ_EN;
    localparam logic [7:0] STA = pmc_pkg::ADDR_STATUS;
    localparam logic [6:0] GA = 7'h7f, GI = 7'h3f, GS = 7'h13, GP = 7'h00;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [2:0] ev;
                    logic [6:0] gi; logic [6:0] go; logic [1:0] st;} pmc_row_t;
    logic        clk, srst, psel, penable, pwrite, dbg_halt, ev_go, e;
    logic [7:0]  paddr, irq_req;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, ext_reset_evt, mcd_reset_evt, rtc_irq;
    logic        other_reset_evt, rtc_alarm, rtc_osc_fail, rtc_reset_req;
    logic [1:0]  cmp_out;
    logic [2:0]  ev_code;
    logic        cpu_fetch_en, system_clock_en, osc_en, dig_periph_run;
    logic        analog_run, irq_timer_en, rtc_run, periph_stall;
    int          fails, compares, n;
    wire  [6:0]  gates = {cpu_fetch_en, system_clock_en, osc_en,
                          dig_periph_run, analog_run, irq_timer_en, rtc_run};
    // enter a mode, fire one event, expected gating before and after
    pmc_row_t rows [11] = '{
        '{PWR, 32'h01, 3'h7, GI, GA, 2'h1}, '{PWR, 32'h01, 3'h2, GI, GA, 2'h1},
        '{PWR, 32'h01, 3'h3, GI, GA, 2'h1}, '{OSC, 32'h20, 3'h3, GS, GA, 2'h2},
        '{OSC, 32'h20, 3'h4, GS, GA, 2'h2}, '{OSC, 32'h20, 3'h5, GS, GA, 2'h2},
        '{OSC, 32'h20, 3'h2, GS, GS, 2'h2}, '{OSC, 32'h20, 3'h1, GS, GA, 2'h2},
        '{PWR, 32'h03, 3'h4, GP, GP, 2'h3}, '{PWR, 32'h02, 3'h1, GP, GA, 2'h3},
        '{PWR, 32'h02, 3'h5, GP, GP, 2'h3}};

    pmc_power_ctrl pmc_power_ctrl_i (.clk, .srst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_req, .ext_reset_evt,
        .mcd_reset_evt, .other_reset_evt, .dbg_halt, .cmp_out, .rtc_alarm,
        .rtc_osc_fail, .cpu_fetch_en, .system_clock_en, .osc_en,
        .dig_periph_run, .analog_run, .irq_timer_en, .rtc_run, .periph_stall,
        .rtc_irq, .rtc_reset_req);
    pmc_far_model pmc_far_model_i (.clk, .srst, .ev_go, .ev_code, .irq_req,
        .ext_reset_evt, .mcd_reset_evt, .other_reset_evt, .cmp_out,
        .rtc_alarm, .rtc_osc_fail);

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, x, g);
        end
    endtask

    // one apb transfer; no fixed latency assumed, only a bounded wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
            fails++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fire(input logic [2:0] c);
        @(posedge clk);
        ev_code <= c;
        ev_go <= 1'b1;
        @(posedge clk);
        ev_go <= 1'b0;
        repeat (8) @(negedge clk);
    endtask

    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run;
    end

    initial
    begin
        {srst, psel, penable, pwrite, dbg_halt, ev_go} = 6'h20;
        {paddr, pwdata, ev_code} = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("gates", GA, gates);
        apb(1'b1, WK, 32'h02f);
        apb(1'b1, IEN, 32'h08);
        apb(1'b0, WK, 32'h0);
        chk("wake_cfg", 32'h02f, q);
        chk("ok_err", 0, e);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            repeat (3) @(negedge clk);
            chk("entered", rows[i].gi, gates);
            apb(1'b0, STA, 32'h0);
            chk("status", rows[i].st, q[1:0]);
            fire(rows[i].ev);
            chk("left", rows[i].go, gates);
            if (rows[i].go !== GA)
                fire(3'h0);
        end
        // refused accesses leave the mode alone
        apb(1'b1, STA, 32'h3);
        chk("ro_err", 1, e);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", 1, e);
        @(negedge clk);
        chk("ro_gates", GA, gates);
        // debug halt stalls peripherals one cycle later
        @(posedge clk);
        dbg_halt <= 1'b1;
        repeat (2) @(negedge clk);
        chk("stall", 1, periph_stall);
        @(posedge clk);
        dbg_halt <= 1'b0;
        repeat (2) @(negedge clk);
        chk("stall_off", 0, periph_stall);
        // oscillator failure routed to a reset request
        apb(1'b1, WK, 32'h200);
        fire(3'h6);
        n = 0;
        chk("no_stray", 0, rtc_reset_req);
        apb(1'b1, WK, 32'h200);
        @(posedge clk);
        ev_code <= 3'h6;
        ev_go <= 1'b1;
        @(posedge clk);
        ev_go <= 1'b0;
        while (rtc_reset_req !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            n++;
        end
        chk("rtc_reset", 1, n < 8);
        // alarm routed to an interrupt pulse instead
        apb(1'b1, WK, 32'h010);
        n = 0;
        @(posedge clk);
        ev_code <= 3'h5;
        ev_go <= 1'b1;
        @(posedge clk);
        ev_go <= 1'b0;
        while (rtc_irq !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            n++;
        end
        chk("rtc_irq", 1, n < 8);
        // reset in mid stop returns everything to its start state
        apb(1'b1, PWR, 32'h2);
        repeat (3) @(negedge clk);
        chk("stop", GP, gates);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("reset_gates", GA, gates);
        apb(1'b0, WK, 32'h0);
        chk("wake_rst", {22'h0, pmc_pkg::WAKE_CFG_RST}, q);
        complete_run;
    end
endmodule

bind pmc_power_ctrl pmc_power_checker pmc_power_checker_i (.clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .ext_reset_evt,
    .mcd_reset_evt, .other_reset_evt, .dbg_halt, .cpu_fetch_en,
    .system_clock_en, .osc_en, .dig_periph_run, .analog_run, .irq_timer_en,
    .rtc_run, .periph_stall);
